/* verilog/pfcs_pkg.sv */
`default_nettype none
package pfcs_pkg;
    localparam int CLK_MHZ = 200;
    // write strobe width; must exceed the 5 ns glitch filter
    localparam int STROBE_NS = 40;
    localparam int STROBE_CYC = (STROBE_NS * CLK_MHZ + 999) / 1000;
    // setup and recovery around each strobe
    localparam int SETUP_NS = 10;
    localparam int SETUP_CYC = (SETUP_NS * CLK_MHZ + 999) / 1000;
    // read cycle time
    localparam int READ_NS = 90;
    localparam int READ_CYC = (READ_NS * CLK_MHZ + 999) / 1000;
    // maximum byte program time
    localparam int PROG_US = 20;
    localparam int PROG_CYC = PROG_US * CLK_MHZ;
    localparam int ADDR_W = 20;
    localparam int CNT_W = 16;
    localparam logic [19:0] UNLOCK_A1 = 20'h05555;
    localparam logic [19:0] UNLOCK_A2 = 20'h02AAA;
    localparam logic [7:0] UNLOCK_D1 = 8'hAA;
    localparam logic [7:0] UNLOCK_D2 = 8'h55;
    localparam logic [7:0] CODE_PROG = 8'hA0;
    localparam logic [7:0] CODE_ERASE = 8'h80;
    localparam logic [7:0] CODE_SECTOR = 8'h30;
    localparam logic [7:0] CODE_BLOCK = 8'h50;
    localparam logic [7:0] CODE_CHIP = 8'h10;
    localparam int SECTOR_LSB = 12;
    localparam int BLOCK_LSB = 16;
    localparam int POLL_BIT = 7;
    localparam int TOGGLE_BIT = 6;
    typedef enum logic [2:0]
    {
        PFCS_OP_READ,
        PFCS_OP_PROG,
        PFCS_OP_SECTOR,
        PFCS_OP_BLOCK,
        PFCS_OP_CHIP
    } pfcs_op_e;
endpackage
`default_nettype wire

/* verilog/pfcs_bus_cycle.sv */
`default_nettype none
// one bus cycle on the flash pins: write or read
module pfcs_bus_cycle (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic clkEn,
    input wire logic start,
    input wire logic isWrite,
    input wire logic [19:0] addrIn,
    input wire logic [7:0] dataIn,
    input wire logic [7:0] flashDqIn,
    output logic busy,
    output logic done,
    output logic [7:0] rdData,
    output logic flashCeN,
    output logic flashOeN,
    output logic flashWeN,
    output logic [19:0] flashAddr,
    output logic [7:0] flashDqOut,
    output logic flashDqOe
);
    typedef enum logic [1:0] {BC_IDLE, BC_SETUP, BC_STROBE, BC_HOLD} pfcs_bc_e;
    typedef struct packed {
        pfcs_bc_e st;
        logic [7:0] cnt;
        logic wr;
        logic ce;
        logic oe;
        logic we;
        logic [19:0] addr;
        logic [7:0] dout;
        logic [7:0] rd;
        logic done;
    } pfcs_bc_s;
    pfcs_bc_s s_q, s_d;

    always_comb
    begin
        s_d = s_q;
        s_d.done = 1'b0;
        case (s_q.st)
            BC_IDLE:
            begin
                s_d.ce = 1'b1;
                s_d.oe = 1'b1;
                s_d.we = 1'b1;
                if (start)
                begin
                    s_d.st = BC_SETUP;
                    s_d.wr = isWrite;
                    s_d.addr = addrIn;
                    s_d.dout = dataIn;
                    s_d.ce = 1'b0;
                    s_d.cnt = 8'(pfcs_pkg::SETUP_CYC);
                end
            end
            BC_SETUP:
            begin
                if (s_q.cnt <= 8'h01)
                begin
                    s_d.st = BC_STROBE;
                    // (R1) strobe under select
                    if (s_q.wr)
                    begin
                        s_d.we = 1'b0;
                        s_d.cnt = 8'(pfcs_pkg::STROBE_CYC);
                    end
                    else
                    begin
                        s_d.oe = 1'b0;
                        s_d.cnt = 8'(pfcs_pkg::READ_CYC);
                    end
                end
                else
                    s_d.cnt = s_q.cnt - 8'h01;
            end
            BC_STROBE:
            begin
                if (s_q.cnt <= 8'h01)
                begin
                    s_d.st = BC_HOLD;
                    s_d.we = 1'b1;
                    s_d.oe = 1'b1;
                    s_d.rd = flashDqIn;
                    s_d.cnt = 8'(pfcs_pkg::SETUP_CYC);
                end
                else
                    s_d.cnt = s_q.cnt - 8'h01;
            end
            BC_HOLD:
            begin
                if (s_q.cnt <= 8'h01)
                begin
                    s_d.st = BC_IDLE;
                    s_d.ce = 1'b1;
                    s_d.done = 1'b1;
                end
                else
                    s_d.cnt = s_q.cnt - 8'h01;
            end
            default:
                s_d.st = BC_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            s_q <= '{st: BC_IDLE, ce: 1'b1, oe: 1'b1, we: 1'b1, default: '0};
        else if (clkEn)
            s_q <= s_d;
    end

    assign busy = (s_q.st != BC_IDLE);
    assign done = s_q.done;
    assign rdData = s_q.rd;
    assign flashCeN = s_q.ce;
    assign flashOeN = s_q.oe;
    assign flashWeN = s_q.we;
    assign flashAddr = s_q.addr;
    assign flashDqOut = s_q.dout;
    // (R20) drive bus only for writes, output gate high
    assign flashDqOe = s_q.wr && (s_q.st != BC_IDLE);

    // (R5) no contention
    dq_contention_a: assert property (@(posedge clk) disable iff (!arst_n)
        flashDqOe |-> flashOeN) else $error("data driven while output gate low");
    strobe_width_a: assert property (@(posedge clk) disable iff (!arst_n) // (R19)
        $fell(flashWeN) && clkEn |-> !flashWeN [*8]) else $error("write strobe too short");
    we_under_ce_a: assert property (@(posedge clk) disable iff (!arst_n) // (R1)
        !flashWeN |-> !flashCeN) else $error("write strobe without select");
endmodule
`default_nettype wire

/* verilog/pfcs_host.sv */
`default_nettype none
// Summary of operation
// (R1) Each command cycle pulses write strobe low while chip select stays low.
// (R2) Address and data stay stable across the whole strobe, for either latching edge.
// (R3) Reads are plain cycles; device wakes itself, host adds no delay.
// (R4) Power-up low-power exclusion is device internal; host idles select high.
// (R5) Host drives data only while output gate is high, samples when both low.
// (R6) Select is high whenever the host is idle.
// (R7) Host software erases the sector before programming a byte.
// (R8) Program sends three unlock cycles then address and data.
// (R9) Program polling gives up after the twenty microsecond bound.
// (R10) During programming the host only reads status, sends no commands.
// (R11) Sector address is aligned to 4 KB, block to 64 KB.
// (R12) Sector erase sends six cycles ending with sector code at sector address.
// (R13) Block erase sends six cycles ending with block code at block address.
// (R14) Sixth cycle carries target address and erase code in one strobe.
// (R15) No command is issued while an erase runs.
// (R16) Chip erase sends six cycles ending with chip code at unlock address.
// (R17) During chip erase the host only polls status.
// (R18) Polling starts right after the launching strobe.
// (R19) Write strobe is always much wider than five nanoseconds.
// (R20) Output gate stays high during every write cycle.
// (R21) Done when completion bit shows written data, or one after erase.
// (R22) Done when two consecutive reads show the toggle bit steady.
// (R23) Sequences are always sent whole, so no aborts are provoked.
// (R24) After completion the host accepts a new operation.
// (R25) Host waits for completion before issuing the next sequence; after an (R9) program timeout it goes idle without completion.
module pfcs_host (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic clkEn,
    input wire logic reqValid,
    output logic reqReady,
    input wire logic [2:0] reqOp,
    input wire logic [19:0] reqAddr,
    input wire logic [7:0] reqData,
    output logic rspValid,
    output logic [7:0] rspData,
    output logic rspTimeout,
    input wire logic [7:0] flashDqIn,
    output logic flashCeN,
    output logic flashOeN,
    output logic flashWeN,
    output logic [19:0] flashAddr,
    output logic [7:0] flashDqOut,
    output logic flashDqOe
);
    typedef enum logic [2:0] {H_IDLE, H_ISSUE, H_WAIT, H_POLL, H_POLLWAIT, H_DONE} pfcs_h_e;
    typedef struct packed {
        pfcs_h_e st;
        pfcs_pkg::pfcs_op_e op;
        logic [2:0] step;
        logic [19:0] addr;
        logic [7:0] data;
        logic [7:0] prev;
        logic havePrev;
        logic [31:0] tmr;
        logic [7:0] rsp;
        logic tout;
        logic rv;
    } pfcs_h_s;
    pfcs_h_s s_q, s_d;

    logic bcStart, bcWrite, bcBusy, bcDone;
    logic [19:0] bcAddr;
    logic [7:0] bcData, bcRd;
    logic [2:0] lastStep;
    logic [19:0] alignAddr;

    pfcs_bus_cycle u_cycle (
        .clk(clk),
        .arst_n(arst_n),
        .clkEn(clkEn),
        .start(bcStart),
        .isWrite(bcWrite),
        .addrIn(bcAddr),
        .dataIn(bcData),
        .flashDqIn(flashDqIn),
        .busy(bcBusy),
        .done(bcDone),
        .rdData(bcRd),
        .flashCeN(flashCeN),
        .flashOeN(flashOeN),
        .flashWeN(flashWeN),
        .flashAddr(flashAddr),
        .flashDqOut(flashDqOut),
        .flashDqOe(flashDqOe)
    );

    // (R11) target alignment
    always_comb
    begin
        alignAddr = s_q.addr;
        if (s_q.op == pfcs_pkg::PFCS_OP_SECTOR)
            alignAddr[pfcs_pkg::SECTOR_LSB-1:0] = '0;
        else if (s_q.op == pfcs_pkg::PFCS_OP_BLOCK)
            alignAddr[pfcs_pkg::BLOCK_LSB-1:0] = '0;
    end

    // (R8) (R12) (R13) (R16) sequence tables
    always_comb
    begin
        lastStep = (s_q.op == pfcs_pkg::PFCS_OP_PROG) ? 3'h3 : 3'h5;
        bcWrite = (s_q.op != pfcs_pkg::PFCS_OP_READ) && (s_q.st == H_ISSUE);
        bcAddr = s_q.addr;
        bcData = s_q.data;
        case (s_q.step)
            3'h0, 3'h3:
            begin
                bcAddr = pfcs_pkg::UNLOCK_A1;
                bcData = pfcs_pkg::UNLOCK_D1;
            end
            3'h1, 3'h4:
            begin
                bcAddr = pfcs_pkg::UNLOCK_A2;
                bcData = pfcs_pkg::UNLOCK_D2;
            end
            3'h2:
            begin
                bcAddr = pfcs_pkg::UNLOCK_A1;
                bcData = (s_q.op == pfcs_pkg::PFCS_OP_PROG) ?
                    pfcs_pkg::CODE_PROG : pfcs_pkg::CODE_ERASE;
            end
            default:
                bcAddr = s_q.addr;
        endcase
        // (R8) (R14) final cycle target and code
        if (s_q.step == lastStep)
        begin
            bcAddr = (s_q.op == pfcs_pkg::PFCS_OP_CHIP) ? pfcs_pkg::UNLOCK_A1 : alignAddr;
            bcData = (s_q.op == pfcs_pkg::PFCS_OP_PROG) ? s_q.data :
                     (s_q.op == pfcs_pkg::PFCS_OP_SECTOR) ? pfcs_pkg::CODE_SECTOR :
                     (s_q.op == pfcs_pkg::PFCS_OP_BLOCK) ? pfcs_pkg::CODE_BLOCK :
                     pfcs_pkg::CODE_CHIP;
        end
        if (s_q.st == H_POLL || s_q.op == pfcs_pkg::PFCS_OP_READ)
            bcAddr = alignAddr;
    end

    always_comb
    begin
        s_d = s_q;
        s_d.rv = 1'b0;
        bcStart = 1'b0;
        case (s_q.st)
            H_IDLE:
            begin
                // (R24) accept new work when idle
                if (reqValid)
                begin
                    // reserved codes fall back to plain reads
                    s_d.op = (reqOp > 3'h4) ? pfcs_pkg::PFCS_OP_READ :
                        pfcs_pkg::pfcs_op_e'(reqOp);
                    s_d.addr = reqAddr;
                    s_d.data = reqData;
                    s_d.step = 3'h0;
                    s_d.st = H_ISSUE;
                end
            end
            H_ISSUE:
            begin
                bcStart = 1'b1;
                s_d.st = H_WAIT;
            end
            H_WAIT:
            begin
                if (bcDone)
                begin
                    if (s_q.op == pfcs_pkg::PFCS_OP_READ)
                    begin
                        s_d.rsp = bcRd;
                        s_d.tout = 1'b0;
                        s_d.st = H_DONE;
                    end
                    else if (s_q.step == lastStep)
                    begin
                        // (R18) poll from the launching strobe onward
                        s_d.havePrev = 1'b0;
                        s_d.tmr = '0;
                        s_d.st = H_POLL;
                    end
                    else
                    begin
                        s_d.step = s_q.step + 3'h1;
                        s_d.st = H_ISSUE;
                    end
                end
            end
            H_POLL:
            begin
                // (R10) (R15) (R17) only status reads while busy
                bcStart = 1'b1;
                s_d.st = H_POLLWAIT;
            end
            H_POLLWAIT:
            begin
                s_d.tmr = s_q.tmr + 32'h1;
                if (bcDone)
                begin
                    s_d.prev = bcRd;
                    s_d.havePrev = 1'b1;
                    // (R22) steady toggle and (R21) expected completion bit
                    if (s_q.havePrev &&
                        s_q.prev[pfcs_pkg::TOGGLE_BIT] == bcRd[pfcs_pkg::TOGGLE_BIT] &&
                        bcRd[pfcs_pkg::POLL_BIT] == ((s_q.op == pfcs_pkg::PFCS_OP_PROG) ?
                            s_q.data[pfcs_pkg::POLL_BIT] : 1'b1))
                    begin
                        s_d.rsp = bcRd;
                        s_d.tout = 1'b0;
                        s_d.st = H_DONE;
                    end
                    // (R9) program bound exceeded
                    else if (s_q.op == pfcs_pkg::PFCS_OP_PROG &&
                             s_q.tmr >= 32'(pfcs_pkg::PROG_CYC))
                    begin
                        s_d.rsp = bcRd;
                        s_d.tout = 1'b1;
                        s_d.st = H_DONE;
                    end
                    else
                        s_d.st = H_POLL;
                end
            end
            H_DONE:
            begin
                // (R25) response after completion, or after the (R9) program timeout
                s_d.rv = 1'b1;
                s_d.st = H_IDLE;
            end
            default:
                s_d.st = H_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            s_q <= '{st: H_IDLE, op: pfcs_pkg::PFCS_OP_READ, default: '0};
        else if (clkEn)
            s_q <= s_d;
    end

    assign reqReady = (s_q.st == H_IDLE);
    assign rspValid = s_q.rv;
    assign rspData = s_q.rsp;
    assign rspTimeout = s_q.tout;

    sequence launch_s;
        bcDone && s_q.st == H_WAIT && s_q.step == lastStep && s_q.op != pfcs_pkg::PFCS_OP_READ;
    endsequence
    // (R18) polling follows launch
    poll_follows_a: assert property (@(posedge clk) disable iff (!arst_n)
        launch_s and clkEn |=> s_q.st == H_POLL) else $error("no polling after launch");
    // (R10) no writes while polling
    poll_read_only_a: assert property (@(posedge clk) disable iff (!arst_n)
        s_q.st == H_POLLWAIT |-> !flashDqOe) else $error("write during polling");
    idle_deselect_a: assert property (@(posedge clk) disable iff (!arst_n) // (R6)
        s_q.st == H_IDLE && !bcBusy |-> flashCeN) else $error("select low while idle");
    ready_idle_a: assert property (@(posedge clk) disable iff (!arst_n) // (R25)
        reqReady |-> !bcBusy) else $error("ready while bus busy");
    chip_final_addr_a: assert property (@(posedge clk) disable iff (!arst_n) // (R16)
        s_q.op == pfcs_pkg::PFCS_OP_CHIP && s_q.step == 3'h5 && !flashWeN
        |-> flashAddr == pfcs_pkg::UNLOCK_A1 && flashDqOut == pfcs_pkg::CODE_CHIP)
        else $error("bad chip erase final cycle");
    prog_final_cycle_a: assert property (@(posedge clk) disable iff (!arst_n) // (R8)
        s_q.op == pfcs_pkg::PFCS_OP_PROG && s_q.step == 3'h3 && !flashWeN
        |-> flashAddr == s_q.addr && flashDqOut == s_q.data)
        else $error("bad program data cycle");
endmodule
`default_nettype wire

/* verif/pfcs_flash_model.sv */
`default_nettype none
// behavioural byte-wide flash on the far side of the pins
module pfcs_flash_model (
    input wire logic ceN,
    input wire logic oeN,
    input wire logic weN,
    input wire logic [19:0] addr,
    input wire logic [7:0] dqIn,
    input wire logic slowMode,
    output logic [7:0] dqOut,
    output int badWrites
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam realtime FAST_NS = 1500.0;
    localparam realtime SLOW_NS = 25000.0;
    localparam realtime ERASE_NS = 3000.0;
    logic [7:0] mem [0:1048575];
    logic [19:0] latA;
    logic [7:0] progData;
    logic isErase;
    logic tog;
    logic inWr;
    int step;
    realtime fallAt;
    realtime doneAt;
    initial
    begin
        for (int i = 0; i < 1048576; i++)
            mem[i] = 8'hFF;
        step = 0;
        doneAt = 0.0;
        badWrites = 0;
        {tog, inWr, isErase, progData, dqOut} = '0;
    end
    task automatic eraseRange(input logic [19:0] base, input int len);
        for (int i = 0; i < len; i++)
            mem[base + 20'(i)] = 8'hFF;
        isErase = 1'b1;
        doneAt = $realtime + ERASE_NS;
    endtask
    task automatic accept(input logic [19:0] a, input logic [7:0] d);
        logic u1;
        logic u2;
        u1 = (a == pfcs_pkg::UNLOCK_A1) && (d == pfcs_pkg::UNLOCK_D1);
        u2 = (a == pfcs_pkg::UNLOCK_A2) && (d == pfcs_pkg::UNLOCK_D2);
        if ($realtime < doneAt)
        begin
            badWrites++;
            return;
        end
        case (step)
            0: step = u1 ? 1 : 0;
            1: step = u2 ? 2 : 0;
            2: step = (a != pfcs_pkg::UNLOCK_A1) ? 0 : (d == pfcs_pkg::CODE_PROG) ? 6 :
                      (d == pfcs_pkg::CODE_ERASE) ? 3 : 0;
            3: step = u1 ? 4 : 0;
            4: step = u2 ? 5 : 0;
            5:
            begin
                step = 0;
                if (d == pfcs_pkg::CODE_SECTOR)
                    eraseRange({a[19:12], 12'h000}, 4096);
                else if (d == pfcs_pkg::CODE_BLOCK)
                    eraseRange({a[19:16], 16'h0000}, 65536);
                else if (d == pfcs_pkg::CODE_CHIP && a == pfcs_pkg::UNLOCK_A1)
                    eraseRange(20'h00000, 1048576);
            end
            default:
            begin
                step = 0;
                if ((mem[a] & d) != d)
                    badWrites++;
                mem[a] = mem[a] & d;
                progData = d;
                isErase = 1'b0;
                doneAt = $realtime + (slowMode ? SLOW_NS : FAST_NS);
            end
        endcase
    endtask
    always @(negedge weN or negedge ceN)
        if (!weN && !ceN)
        begin
            latA = addr;
            fallAt = $realtime;
            inWr = 1'b1;
        end
    always @(posedge weN or posedge ceN)
        if (inWr)
        begin
            inWr = 1'b0;
            if ($realtime - fallAt < 5.0 || !oeN)
                badWrites++;
            else
                accept(latA, dqIn);
        end
    always @(posedge oeN)
        if (!ceN && $realtime < doneAt)
            tog = ~tog;
    always @(ceN, oeN, addr)
        if (!ceN && !oeN)
            dqOut = ($realtime < doneAt) ? {isErase ? 1'b0 : ~progData[7], tog, 6'h2A} : mem[addr];
        else
            dqOut = ~dqOut;
endmodule
`default_nettype wire

/* verif/parallel_flash_command_sequencer_tb_top.sv */
`default_nettype none
module parallel_flash_command_sequencer_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {
        logic [2:0] op;
        logic [19:0] addr;
        logic [7:0] data;
        logic [7:0] expData;
        logic [7:0] expMask;
    } pfcs_row_s;
    pfcs_row_s rows [14] = '{
        '{3'h0, 20'h12345, 8'h00, 8'hFF, 8'hFF}, '{3'h1, 20'h12345, 8'h3C, 8'h3C, 8'hFF},
        '{3'h0, 20'h12345, 8'h00, 8'h3C, 8'hFF}, '{3'h1, 20'h13000, 8'h5A, 8'h5A, 8'hFF},
        '{3'h1, 20'h12346, 8'h81, 8'h81, 8'hFF}, '{3'h2, 20'h12FFF, 8'h00, 8'h00, 8'h00},
        '{3'h0, 20'h12345, 8'h00, 8'hFF, 8'hFF}, '{3'h0, 20'h13000, 8'h00, 8'h5A, 8'hFF},
        '{3'h1, 20'h20000, 8'h77, 8'h77, 8'hFF}, '{3'h3, 20'h1ABCD, 8'h00, 8'h00, 8'h00},
        '{3'h0, 20'h13000, 8'h00, 8'hFF, 8'hFF}, '{3'h0, 20'h20000, 8'h00, 8'h77, 8'hFF},
        '{3'h4, 20'h00000, 8'h00, 8'h00, 8'h00}, '{3'h7, 20'h20000, 8'h00, 8'hFF, 8'hFF}};
    logic clk = 1'b0;
    logic arst_n;
    logic clkEn;
    logic reqValid;
    logic reqReady;
    logic [2:0] reqOp;
    logic [19:0] reqAddr;
    logic [7:0] reqData;
    logic rspValid;
    logic [7:0] rspData;
    logic rspTimeout;
    logic [7:0] flashDqIn;
    logic flashCeN;
    logic flashOeN;
    logic flashWeN;
    logic [19:0] flashAddr;
    logic [7:0] flashDqOut;
    logic flashDqOe;
    logic [7:0] devDq;
    logic slowMode;
    int badWrites;
    int errTotal = 0;
    int numChecks = 0;
    int cycles = 0;
    assign flashDqIn = flashDqOe ? flashDqOut : devDq;
    pfcs_host DUT (
        .clk(clk), .arst_n(arst_n), .clkEn(clkEn), .reqValid(reqValid), .reqReady(reqReady),
        .reqOp(reqOp), .reqAddr(reqAddr), .reqData(reqData), .rspValid(rspValid),
        .rspData(rspData), .rspTimeout(rspTimeout), .flashDqIn(flashDqIn),
        .flashCeN(flashCeN), .flashOeN(flashOeN), .flashWeN(flashWeN),
        .flashAddr(flashAddr), .flashDqOut(flashDqOut), .flashDqOe(flashDqOe));
    pfcs_flash_model flash (
        .ceN(flashCeN), .oeN(flashOeN), .weN(flashWeN), .addr(flashAddr), .dqIn(flashDqIn),
        .slowMode(slowMode), .dqOut(devDq), .badWrites(badWrites));
    always #2.5 clk = ~clk;
    task automatic check(input logic [8:0] got, input logic [8:0] exp);
        numChecks++;
        if (got !== exp)
        begin
            errTotal++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic endOfTest();
        $display("checks %0d errors %0d", numChecks, errTotal);
        if (errTotal == 0 && numChecks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic doReq(input logic [2:0] op, input logic [19:0] a, input logic [7:0] d,
                         input int lim);
        int n;
        {reqOp, reqAddr, reqData, reqValid} = {op, a, d, 1'b1};
        n = 0;
        while (reqReady !== 1'b1 && n < 100)
        begin
            @(negedge clk);
            n++;
        end
        @(negedge clk);
        reqValid = 1'b0;
        n = 0;
        while (rspValid !== 1'b1 && n < lim)
        begin
            @(negedge clk);
            n++;
        end
        check(9'(rspValid), 9'h001);
    endtask
    // strobe discipline on every cycle
    always @(negedge clk)
        if (arst_n && !flashWeN)
            check({7'h00, flashOeN, flashCeN}, 9'h002);
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 60000)
        begin
            errTotal++;
            endOfTest();
        end
    end
    initial
    begin
        {arst_n, reqValid, reqOp, reqAddr, reqData, slowMode} = '0;
        clkEn = 1'b1;
        repeat (8) @(negedge clk);
        check({3'h0, flashCeN, flashOeN, flashWeN, flashDqOe, reqReady, rspValid}, 9'h03A);
        arst_n = 1'b1;
        foreach (rows[i])
        begin
            doReq(rows[i].op, rows[i].addr, rows[i].data, 20000);
            check({rspTimeout, rspData & rows[i].expMask},
                  {1'b0, rows[i].expData & rows[i].expMask});
        end
        slowMode = 1'b1;
        doReq(3'h1, 20'h30000, 8'h11, 6000);
        check(9'(rspTimeout), 9'h001);
        slowMode = 1'b0;
        repeat (2000) @(negedge clk);
        {reqOp, reqAddr, reqValid} = {3'h0, 20'h30000, 1'b1};
        @(negedge clk);
        reqValid = 1'b0;
        repeat (10) @(negedge clk);
        arst_n = 1'b0;
        @(negedge clk);
        check({3'h0, flashCeN, flashOeN, flashWeN, flashDqOe, reqReady, rspValid},
              9'h03A);
        arst_n = 1'b1;
        fork
            doReq(3'h0, 20'h30000, 8'h00, 200);
            begin
                repeat (12) @(negedge clk);
                clkEn = 1'b0;
                repeat (20) @(negedge clk);
                clkEn = 1'b1;
            end
        join
        check({rspTimeout, rspData}, 9'h011);
        check({1'b0, 8'(badWrites)}, 9'h000);
        endOfTest();
    end
endmodule
`default_nettype wire
